// ---- include/sector_mem_regs.vh ----
// register offsets, field positions and reset values of the sectored data memory
`ifndef SECTOR_MEM_REGS_VH
`define SECTOR_MEM_REGS_VH
`define OFS_INDIRECT_PORT_ZERO 8'h00
`define OFS_POINTER_ZERO 8'h01
`define OFS_INDIRECT_PORT_ONE 8'h02
`define OFS_POINTER_ONE_LOW 8'h03
`define OFS_POINTER_ONE_SECTOR 8'h04
`define OFS_INDIRECT_PORT_TWO 8'h0c
`define OFS_POINTER_TWO_LOW 8'h0d
`define OFS_POINTER_TWO_SECTOR 8'h0e
`define GP_REGION_BIT 7
`define PTR_RESET 8'h00
`define UNUSED_READ 8'h00
`endif

// ---- design/gp_ram.v ----
// general purpose ram array, byte wide, one sector per 128 bytes
`timescale 1ns/10ps
module gp_ram #(
   parameter AW = 10
) (
   mclk,
   we,
   waddr,
   wdata,
   raddr,
   rdata
);
   input wire mclk;
   input wire we;
   input wire [AW-1:0] waddr;
   input wire [7:0] wdata;
   input wire [AW-1:0] raddr;
   output wire [7:0] rdata;

   reg [7:0] mem_r [0:(1<<AW)-1];

   // asynchronous read keeps a read-modify-write within one cycle
   assign rdata = mem_r[raddr];

   always @(posedge mclk)
   begin
      if (we)
         mem_r[waddr] <= wdata;
   end
endmodule // gp_ram

// ---- design/sector_mem.v ----
// sectored byte-wide data memory with direct, extended and indirect decode
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
// Summary of operation
// - every location is an eight-bit cell read and written whole.
// - offsets 00h to 7fh of a sector are special registers, never ram.
// - offsets 80h to ffh of a sector are readable, writable ram.
// - no sector register; indirect sector comes from the pointer high.
// - extended addresses are SEC_BITS+8 bits (11), upper SEC_BITS pick the sector.
// - extended accesses reach any sector without the pointers.
// - unused special locations read as 00h.
// - protected special registers ignore program writes.
// - bit set and clear change only the addressed ram bit.
// - each special register sits at a fixed address.
// - indirect ports redirect through their pointer, hold no data.
// - port zero reaches sector zero only, ports one and two any.
`timescale 1ns/10ps
`include "sector_mem_regs.vh"
module sector_mem #(
   parameter SECTORS = 8,
   parameter SEC_BITS = 3
) (
   mclk,
   srst,
   acc_en,
   acc_wr,
   acc_ext,
   acc_addr,
   acc_wdata,
   bit_op,
   bit_set,
   bit_sel,
   acc_rdata,
   sfr_sel,
   sfr_addr,
   sfr_rdata,
   sfr_wr,
   sfr_ro,
   sfr_used,
   sfr_wdata
);
   input wire mclk;
   input wire srst;
   input wire acc_en;
   input wire acc_wr;
   input wire acc_ext;
   input wire [SEC_BITS+7:0] acc_addr;
   input wire [7:0] acc_wdata;
   input wire bit_op;
   input wire bit_set;
   input wire [2:0] bit_sel;
   output reg [7:0] acc_rdata;
   output wire sfr_sel;
   output wire [SEC_BITS+7:0] sfr_addr;
   input wire [7:0] sfr_rdata;
   output wire sfr_wr;
   input wire sfr_ro;
   input wire sfr_used;
   output wire [7:0] sfr_wdata;

   localparam AW = SEC_BITS + 7;

   // ---------------------------------------------------------------
   // offset decode used by the target checks; the redirect compares raw_ofs itself
   // ---------------------------------------------------------------
   // true for the three indirect port offsets of sector zero
   function port_ofs;
      input [7:0] ofs;
      begin
         port_ofs = (ofs == `OFS_INDIRECT_PORT_ZERO) ||
            (ofs == `OFS_INDIRECT_PORT_ONE) ||
            (ofs == `OFS_INDIRECT_PORT_TWO);
      end
   endfunction

   // true for the five pointer offsets of sector zero
   function ptr_ofs;
      input [7:0] ofs;
      begin
         ptr_ofs = (ofs == `OFS_POINTER_ZERO) ||
            (ofs == `OFS_POINTER_ONE_LOW) ||
            (ofs == `OFS_POINTER_ONE_SECTOR) ||
            (ofs == `OFS_POINTER_TWO_LOW) ||
            (ofs == `OFS_POINTER_TWO_SECTOR);
      end
   endfunction

   // ---------------------------------------------------------------
   // memory pointers
   // ---------------------------------------------------------------
   reg [7:0] pointer_zero_r;
   reg [7:0] pointer_one_low_r;
   reg [7:0] pointer_one_sector_r;
   reg [7:0] pointer_two_low_r;
   reg [7:0] pointer_two_sector_r;

   // ---------------------------------------------------------------
   // address resolution
   // ---------------------------------------------------------------
   wire [7:0] raw_ofs = acc_addr[7:0];
   wire [SEC_BITS-1:0] raw_sec =
      acc_ext ? acc_addr[SEC_BITS+7:8] : {SEC_BITS{1'b0}};
   wire to_port0 = (raw_sec == 0) && (raw_ofs == `OFS_INDIRECT_PORT_ZERO);
   wire to_port1 = (raw_sec == 0) && (raw_ofs == `OFS_INDIRECT_PORT_ONE);
   wire to_port2 = (raw_sec == 0) && (raw_ofs == `OFS_INDIRECT_PORT_TWO);

   reg [7:0] eff_ofs;
   reg [7:0] eff_sec;
   always @*
   begin
      eff_ofs = raw_ofs;
      eff_sec = {{(8-SEC_BITS){1'b0}}, raw_sec};
      if (to_port0)
      begin
         eff_ofs = pointer_zero_r;
         eff_sec = 8'h00;
      end
      else if (to_port1)
      begin
         eff_ofs = pointer_one_low_r;
         eff_sec = pointer_one_sector_r;
      end
      else if (to_port2)
      begin
         eff_ofs = pointer_two_low_r;
         eff_sec = pointer_two_sector_r;
      end
   end

   // sectors past the parameter, or pointer high bits past the width, are
   // treated as unused so a stray pointer can never alias a real sector
   wire sec_ok = (eff_sec < SECTORS);
   wire is_gp = eff_ofs[`GP_REGION_BIT];
   // the port locations themselves hold nothing when reached indirectly
   wire is_port = (eff_sec == 8'h00) && port_ofs(eff_ofs);
   wire is_ptr = (eff_sec == 8'h00) && ptr_ofs(eff_ofs);
   wire [AW-1:0] ram_addr = {eff_sec[SEC_BITS-1:0], eff_ofs[6:0]};

   // ---------------------------------------------------------------
   // ram and byte merge
   // ---------------------------------------------------------------
   wire [7:0] ram_rdata;
   wire [7:0] bit_mask = 8'h01 << bit_sel;
   wire [7:0] ram_wdata = !bit_op ? acc_wdata :
      bit_set ? (ram_rdata | bit_mask) : (ram_rdata & ~bit_mask);
   wire ram_we = acc_en && acc_wr && is_gp && sec_ok;

   gp_ram #(
      .AW(AW)
   ) u_ram (
      .mclk(mclk),
      .we(ram_we),
      .waddr(ram_addr),
      .wdata(ram_wdata),
      .raddr(ram_addr),
      .rdata(ram_rdata)
   );

   // ---------------------------------------------------------------
   // special region passthrough to the rest of the core
   // ---------------------------------------------------------------
   wire sfr_hit = !is_gp && sec_ok && !is_port && !is_ptr;
   assign sfr_sel = acc_en && sfr_hit;
   assign sfr_addr = {eff_sec[SEC_BITS-1:0], eff_ofs};
   assign sfr_wr = acc_en && acc_wr && sfr_hit && sfr_used && !sfr_ro;
   assign sfr_wdata = ram_wdata;

   // ---------------------------------------------------------------
   // pointer registers
   // ---------------------------------------------------------------
   wire ptr_we = acc_en && acc_wr && is_ptr;
   always @(posedge mclk)
   begin
      if (srst)
      begin
         pointer_zero_r <= `PTR_RESET;
         pointer_one_low_r <= `PTR_RESET;
         pointer_one_sector_r <= `PTR_RESET;
         pointer_two_low_r <= `PTR_RESET;
         pointer_two_sector_r <= `PTR_RESET;
      end
      else if (ptr_we)
      begin
         case (eff_ofs)
            `OFS_POINTER_ZERO: pointer_zero_r <= ram_wdata;
            `OFS_POINTER_ONE_LOW: pointer_one_low_r <= ram_wdata;
            `OFS_POINTER_ONE_SECTOR: pointer_one_sector_r <= ram_wdata;
            `OFS_POINTER_TWO_LOW: pointer_two_low_r <= ram_wdata;
            `OFS_POINTER_TWO_SECTOR: pointer_two_sector_r <= ram_wdata;
            default: pointer_zero_r <= pointer_zero_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read data, registered one cycle after the access
   // ---------------------------------------------------------------
   reg [7:0] ptr_rd;
   always @*
   begin
      case (eff_ofs)
         `OFS_POINTER_ZERO: ptr_rd = pointer_zero_r;
         `OFS_POINTER_ONE_LOW: ptr_rd = pointer_one_low_r;
         `OFS_POINTER_ONE_SECTOR: ptr_rd = pointer_one_sector_r;
         `OFS_POINTER_TWO_LOW: ptr_rd = pointer_two_low_r;
         `OFS_POINTER_TWO_SECTOR: ptr_rd = pointer_two_sector_r;
         default: ptr_rd = `UNUSED_READ;
      endcase
   end

   always @(posedge mclk)
   begin
      if (srst)
         acc_rdata <= `UNUSED_READ;
      else if (acc_en && !acc_wr)
      begin
         if (!sec_ok || is_port)
            acc_rdata <= `UNUSED_READ;
         else if (is_gp)
            acc_rdata <= ram_rdata;
         else if (is_ptr)
            acc_rdata <= ptr_rd;
         else if (sfr_used)
            acc_rdata <= sfr_rdata;
         else
            acc_rdata <= `UNUSED_READ;
      end
   end
endmodule // sector_mem

// ---- sim/sfr_model.sv ----
// behavioural special register file seen behind the memory decode
`timescale 1ns/10ps
module sfr_model (
   input wire mclk,
   input wire sel,
   input wire [10:0] addr,
   input wire wr,
   input wire [7:0] wdata,
   output wire [7:0] rdata,
   output wire used,
   output wire ro
);
   reg [7:0] rw_r = 8'h00;
   reg [7:0] ro_r = 8'h5a;
   // only 020h and 021h of sector 0 exist; unused places drive junk
   assign used = sel && (addr == 11'h020 || addr == 11'h021);
   assign ro = (addr == 11'h021);
   assign rdata = (addr == 11'h021) ? ro_r : used ? rw_r : 8'hc3;
   always @(posedge mclk)
   begin
      if (wr && addr == 11'h020)
         rw_r <= wdata;
      else if (wr && addr == 11'h021)
         ro_r <= wdata; // a protected place only moves if the strobe leaks
   end
endmodule // sfr_model

// ---- sim/sector_mem_assertions.sv ----
// port checker for the sectored data memory
`timescale 1ns/10ps
module sector_mem_checker #(parameter SECTORS = 8, parameter SEC_BITS = 3) (
   input wire mclk, input wire srst, input wire acc_en, input wire acc_wr,
   input wire acc_ext, input wire [SEC_BITS+7:0] acc_addr,
   input wire [7:0] acc_wdata, input wire bit_op, input wire bit_set,
   input wire [2:0] bit_sel, input wire [7:0] acc_rdata, input wire sfr_sel,
   input wire [SEC_BITS+7:0] sfr_addr, input wire [7:0] sfr_rdata,
   input wire sfr_wr, input wire sfr_ro, input wire sfr_used,
   input wire [7:0] sfr_wdata
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   AST_WR_SEL: assert property (
      sfr_wr |-> sfr_sel && acc_en && acc_wr)
      else $error("sfr strobe without a write");
   AST_WR_RO: assert property (sfr_wr |-> sfr_used && !sfr_ro)
      else $error("sfr strobe to protected or unused place");
   AST_SEL_LOW: assert property (sfr_sel |-> !sfr_addr[7])
      else $error("sfr select in ram half");
   AST_FIXED: assert property (
      acc_en && !acc_ext && acc_addr[7:0] == 8'h20
      |-> sfr_sel && sfr_addr == 11'h020)
      else $error("fixed register moved");
   AST_EXT: assert property (
      acc_en && acc_ext && !acc_addr[7] && acc_addr[SEC_BITS+7:8] != 0
      && acc_addr[SEC_BITS+7:8] < SECTORS |-> sfr_sel && sfr_addr == acc_addr)
      else $error("extended sfr address wrong");
   AST_WDATA: assert property (
      sfr_wr && !bit_op |-> sfr_wdata == acc_wdata)
      else $error("sfr write byte wrong");
   AST_UNUSED: assert property (
      acc_en && !acc_wr && sfr_sel && !sfr_used |=> acc_rdata == 8'h00)
      else $error("unused place not zero");
   AST_USED: assert property (
      acc_en && !acc_wr && sfr_sel && sfr_used
      |=> acc_rdata == $past(sfr_rdata))
      else $error("sfr read byte wrong");
   AST_HOLD: assert property (
      !(acc_en && !acc_wr) |=> $stable(acc_rdata))
      else $error("read data moved without a read");
   COV_SFR_WR: cover property (sfr_wr);
   COV_IND: cover property (acc_en && !acc_ext && acc_addr[7:0] == 8'h02);
   COV_EXT_RAM: cover property (acc_en && acc_ext && acc_addr[7]);
   COV_BIT: cover property (acc_en && bit_op);
endmodule // sector_mem_checker
bind sector_mem sector_mem_checker #(.SECTORS(SECTORS), .SEC_BITS(SEC_BITS))
   u_chk (.mclk(mclk), .srst(srst), .acc_en(acc_en), .acc_wr(acc_wr),
   .acc_ext(acc_ext), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
   .bit_op(bit_op), .bit_set(bit_set), .bit_sel(bit_sel),
   .acc_rdata(acc_rdata), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
   .sfr_rdata(sfr_rdata), .sfr_wr(sfr_wr), .sfr_ro(sfr_ro),
   .sfr_used(sfr_used), .sfr_wdata(sfr_wdata));

// ---- sim/sector_mem_bench.sv ----
// self-checking bench for the sectored data memory
`timescale 1ns/10ps
module sector_mem_bench;
   reg mclk = 0, srst = 1, acc_en = 0, acc_wr = 0, acc_ext = 0;
   reg bit_op = 0, bit_set = 0;
   reg [10:0] acc_addr = 0;
   reg [7:0] acc_wdata = 0;
   reg [2:0] bit_sel = 0;
   wire [7:0] acc_rdata, sfr_rdata, sfr_wdata;
   wire [10:0] sfr_addr;
   wire sfr_sel, sfr_wr, sfr_ro, sfr_used;
   integer failures = 0, tests_run = 0;
   sector_mem u_dut (.mclk(mclk), .srst(srst), .acc_en(acc_en),
      .acc_wr(acc_wr), .acc_ext(acc_ext), .acc_addr(acc_addr),
      .acc_wdata(acc_wdata), .bit_op(bit_op), .bit_set(bit_set),
      .bit_sel(bit_sel), .acc_rdata(acc_rdata), .sfr_sel(sfr_sel),
      .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .sfr_wr(sfr_wr),
      .sfr_ro(sfr_ro), .sfr_used(sfr_used), .sfr_wdata(sfr_wdata));
   sfr_model u_sfr (.mclk(mclk), .sel(sfr_sel), .addr(sfr_addr),
      .wr(sfr_wr), .wdata(sfr_wdata), .rdata(sfr_rdata), .used(sfr_used),
      .ro(sfr_ro));
   initial forever #20 mclk = ~mclk;
   task conclude;
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input [7:0] s, input [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         failures++;
         $display("[ERR] %0t read %h expected %h", $time, s, e);
      end
   endtask
   // one access per call; read data is sampled after the taking edge
   task acc(input w, input x, input [10:0] a, input [7:0] d, input b,
      input s, input [2:0] i);
      @(posedge mclk);
      acc_en <= 1; acc_wr <= w; acc_ext <= x; acc_addr <= a;
      acc_wdata <= d; bit_op <= b; bit_set <= s; bit_sel <= i;
      @(posedge mclk);
      acc_en <= 0;
      #1;
   endtask
   task wr(input x, input [10:0] a, input [7:0] d);
      acc(1, x, a, d, 0, 0, 3'h0);
   endtask
   task rd(input x, input [10:0] a, input [7:0] e);
      acc(0, x, a, 8'h00, 0, 0, 3'h0);
      chk(acc_rdata, e);
   endtask
   task t_reset;
      rd(0, 11'h001, 8'h00);
      rd(0, 11'h00e, 8'h00);
   endtask
   task t_ram;
      wr(1, 11'h190, 8'ha5);
      wr(0, 11'h090, 8'h3c);
      wr(1, 11'h7ff, 8'h11);
      rd(1, 11'h190, 8'ha5);
      rd(0, 11'h090, 8'h3c);
      rd(1, 11'h7ff, 8'h11);
   endtask
   task t_ind;
      wr(0, 11'h003, 8'h90);
      wr(0, 11'h004, 8'h01);
      rd(0, 11'h002, 8'ha5);
      wr(0, 11'h00d, 8'hff);
      wr(0, 11'h00e, 8'h07);
      wr(0, 11'h00c, 8'h5e);
      rd(1, 11'h7ff, 8'h5e);
      wr(0, 11'h001, 8'h90);
      rd(0, 11'h000, 8'h3c);
      wr(0, 11'h003, 8'h02);
      wr(0, 11'h004, 8'h00);
      rd(0, 11'h002, 8'h00);
      wr(0, 11'h004, 8'h08);
      wr(0, 11'h003, 8'h90);
      wr(0, 11'h002, 8'haa);
      rd(0, 11'h002, 8'h00);
      rd(0, 11'h090, 8'h3c);
   endtask
   task t_bit;
      wr(0, 11'h0a0, 8'hf0);
      acc(1, 0, 11'h0a0, 8'h00, 1, 1, 3'h1);
      acc(1, 0, 11'h0a0, 8'hff, 1, 0, 3'h7);
      rd(0, 11'h0a0, 8'h72);
   endtask
   task t_sfr;
      wr(0, 11'h020, 8'h33);
      rd(0, 11'h020, 8'h33);
      wr(0, 11'h021, 8'h00);
      rd(0, 11'h021, 8'h5a);
      rd(0, 11'h030, 8'h00);
      wr(1, 11'h120, 8'h44);
      rd(1, 11'h120, 8'h00);
   endtask
   initial
   begin
      #100000;
      failures++;
      conclude;
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      srst <= 0;
      t_reset;
      t_ram;
      t_ind;
      t_bit;
      t_sfr;
      conclude;
   end
endmodule // sector_mem_bench
